// file: design/cis_sequencer.sv
// Interrupt and reset vectoring sequencer of the CPU core, with AHB-Lite registers.
// Operation
// RQ1 - Single core clock, no divider
// RQ2 - Take source only if enabled and global
// RQ3 - Boot lock bits suppress interrupts by PC
// RQ4 - Low vectors; lower address wins; reset first
// RQ5 - Vector select moves vectors to boot
// RQ6 - Boot reset fuse moves reset vector
// RQ7 - Entry clears global enable
// RQ8 - Setting global enable allows nesting
// RQ9 - Return sets global enable
// RQ10 - Entry clears latched pending flag
// RQ11 - Write one clears flag, zero keeps
// RQ12 - Flags held while disabled, served later
// RQ13 - Level sources request while present
// RQ14 - One instruction after return before interrupt
// RQ15 - Handlers save status flags themselves
// RQ16 - Clear-enable blocks same-cycle interrupt
// RQ17 - One instruction after set-enable
// RQ18 - Entry four cycles, pushes PC
// RQ19 - Vector jump takes three cycles
// RQ20 - Multi-cycle instruction completes first
// RQ21 - Wake from sleep adds four cycles
// RQ22 - Return four cycles, pops PC, SP+2
// RQ23 - Entry push decrements SP by two
// RQ24 - Global enable is status bit 7
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module cis_sequencer (
	input  wire logic                        clock,        // Core clock, 40 MHz.
	input  wire logic                        rst,          // Asynchronous reset, active high.
	input  wire logic [11:0]                 haddr,        // AHB address.
	input  wire logic [1:0]                  htrans,       // AHB transfer type.
	input  wire logic                        hwrite,       // AHB write.
	input  wire logic [2:0]                  hsize,        // AHB size.
	input  wire logic                        hsel,         // AHB select.
	input  wire logic                        hready,       // AHB bus ready.
	input  wire logic [31:0]                 hwdata,       // AHB write data.
	output logic      [31:0]                 hrdata,       // AHB read data.
	output logic                             hreadyout,    // AHB slave ready.
	output logic                             hresp,        // AHB response, always OKAY.
	input  wire logic [cis_pkg::NUM_SRC-1:0] src_event,    // Event pulses of latched sources.
	input  wire logic [cis_pkg::NUM_SRC-1:0] src_level,    // Conditions of level sources.
	input  wire logic                        instr_done,   // Pipeline finished an instruction.
	input  wire logic [2:0]                  instr_op,     // Kind of finished instruction.
	input  wire logic                        sleeping,     // Core is in sleep mode.
	input  wire logic [cis_pkg::PC_W-1:0]    pc_in,        // Program counter of next instruction.
	output logic                             irq_take,     // Pipeline must halt for entry.
	output logic      [cis_pkg::PC_W-1:0]    vector_pc,    // Target program counter.
	output logic                             pc_load,      // Load vector_pc, one cycle.
	output logic      [cis_pkg::PC_W-1:0]    stack_pc,     // Program counter pushed.
	output logic                             stack_push,   // Push stack_pc, one cycle.
	output logic                             stack_pop,    // Pop the return address, one cycle.
	output logic      [cis_pkg::SP_W-1:0]    stack_ptr,    // Stack pointer.
	output logic                             global_en     // Status bit 7 mirror.
);

	////////////////////////////////////////////////////////////////////////////////
	// Register bus.
	logic                        wr_pend_q, wr_pend_d;
	logic [11:0]                 wr_addr_q, wr_addr_d;
	logic [31:0]                 rdata_q, rdata_d;
	logic [7:0]                  sflags_q, sflags_d;
	logic [3:0]                  ctrl_q, ctrl_d;
	logic [cis_pkg::NUM_SRC-1:0] ena_q, ena_d;
	logic [cis_pkg::NUM_SRC-1:0] flag_q, flag_d;
	logic [cis_pkg::NUM_SRC-1:0] lvl_q, lvl_d;
	logic [cis_pkg::SP_W-1:0]    sp_q, sp_d;
	logic [cis_pkg::PC_W-1:0]    boot_q, boot_d;
	logic                        addr_ph;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state.
	cis_pkg::cis_state_type      st_q, st_d;
	logic [3:0]                  cnt_q, cnt_d;
	logic                        hold_q, hold_d;
	logic [cis_pkg::PC_W-1:0]    vec_q, vec_d;
	logic [cis_pkg::PC_W-1:0]    pcsave_q, pcsave_d;
	logic                        take_q, take_d;
	logic                        load_q, load_d;
	logic                        push_q, push_d;
	logic                        pop_q, pop_d;
	logic [cis_pkg::NUM_SRC-1:0] clr_src;
	logic [cis_pkg::NUM_SRC-1:0] req;
	logic                        any_req;
	logic [2:0]                  win;
	logic                        locked;
	logic                        cli_now;

	assign addr_ph = hsel & hready & htrans[1];

	// A source pending in the same cycle as a CLI is not taken, because of cli_now; its flag stays set. [RQ16]
	assign cli_now = instr_done & (instr_op == cis_pkg::OP_CLI);

	// Interrupts are suppressed while executing in a locked section. [RQ3]
	always_comb begin
		locked = 1'b0;
		if (ctrl_q[cis_pkg::LOCK_APP_BIT] && pc_in < boot_q)
			locked = 1'b1;
		if (ctrl_q[cis_pkg::LOCK_BOOT_BIT] && pc_in >= boot_q)
			locked = 1'b1;
	end

	// Latched flags or present levels, each gated by its enable. [RQ2] [RQ13]
	assign req = ((flag_q & ~lvl_q) | (src_level & lvl_q)) & ena_q;
	assign any_req = |req;

	// Lowest index is the lowest vector and wins. [RQ4]
	always_comb begin
		win = 3'h0;
		for (int i = cis_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (req[i])
				win = 3'(i);
		end
	end

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		hold_d = hold_q;
		vec_d = vec_q;
		pcsave_d = pcsave_q;
		take_d = 1'b0;
		load_d = 1'b0;
		push_d = 1'b0;
		pop_d = 1'b0;
		clr_src = '0;
		sflags_d = sflags_q;
		sp_d = sp_q;
		if (instr_done && instr_op == cis_pkg::OP_SEI)
			sflags_d[cis_pkg::GIE_BIT] = 1'b1; // [RQ8] [RQ24]
		if (cli_now)
			sflags_d[cis_pkg::GIE_BIT] = 1'b0; // [RQ16]
		case (st_q)
			cis_pkg::ST_RUN: begin
				if (instr_done)
					hold_d = 1'b0;
				if (instr_done && instr_op == cis_pkg::OP_RET_IRQ) begin
					st_d = cis_pkg::ST_RET;
					cnt_d = 4'(cis_pkg::RETURN_CYC - 1);
					pop_d = 1'b1;
				end else if (instr_done && instr_op == cis_pkg::OP_SEI) begin
					hold_d = 1'b1; // [RQ17]
				// Only at an instruction boundary or while sleeping, so multi-cycle ones complete. [RQ20]
				end else if ((instr_done || sleeping) && !hold_q && !cli_now && !locked
						&& sflags_q[cis_pkg::GIE_BIT] && any_req) begin // [RQ2] [RQ12]
					take_d = 1'b1;
					pcsave_d = pc_in;
					// Vector select relocates to the boot section; widen before the +1 so
					// the top source does not wrap to the reset slot. [RQ5]
					vec_d = (ctrl_q[cis_pkg::VSEL_BIT] ? boot_q : cis_pkg::RESET_VEC)
						+ (cis_pkg::PC_W'(win) + cis_pkg::PC_ONE) * cis_pkg::VEC_STRIDE;
					sflags_d[cis_pkg::GIE_BIT] = 1'b0; // [RQ7]
					clr_src[win] = ~lvl_q[win]; // [RQ10]
					if (sleeping) begin
						st_d = cis_pkg::ST_WAKE; // [RQ21]
						cnt_d = 4'(cis_pkg::WAKE_CYC - 1);
					end else begin
						st_d = cis_pkg::ST_ENTRY;
						cnt_d = 4'(cis_pkg::ENTRY_CYC - 1);
					end
				end
			end
			cis_pkg::ST_WAKE: begin
				take_d = 1'b1;
				cnt_d = cnt_q - cis_pkg::CNT_ONE;
				if (cnt_q == cis_pkg::CNT_ZERO) begin
					st_d = cis_pkg::ST_ENTRY;
					cnt_d = 4'(cis_pkg::ENTRY_CYC - 1);
				end
			end
			cis_pkg::ST_ENTRY: begin
				take_d = 1'b1;
				cnt_d = cnt_q - cis_pkg::CNT_ONE;
				// Four entry cycles; push and SP-2 at the third, vector load at the last. [RQ18] [RQ23]
				if (cnt_q == cis_pkg::CNT_ONE) begin
					push_d = 1'b1;
					sp_d = sp_q - cis_pkg::SP_STEP;
				end
				if (cnt_q == cis_pkg::CNT_ZERO) begin
					take_d = 1'b0;
					load_d = 1'b1;
					st_d = cis_pkg::ST_JUMP;
					cnt_d = 4'(cis_pkg::JUMP_CYC - 1);
				end
			end
			cis_pkg::ST_JUMP: begin
				// The jump placed at the vector occupies three cycles. [RQ19]
				cnt_d = cnt_q - cis_pkg::CNT_ONE;
				if (cnt_q == cis_pkg::CNT_ZERO)
					st_d = cis_pkg::ST_RUN;
			end
			cis_pkg::ST_RET: begin
				cnt_d = cnt_q - cis_pkg::CNT_ONE;
				if (cnt_q == cis_pkg::CNT_ZERO) begin
					// Pop done, SP+2, global enable set. [RQ9] [RQ22]
					sp_d = sp_q + cis_pkg::SP_STEP;
					sflags_d[cis_pkg::GIE_BIT] = 1'b1;
					hold_d = 1'b1; // [RQ14]
					st_d = cis_pkg::ST_RUN;
				end
			end
			default: st_d = cis_pkg::ST_RUN;
		endcase
	end

	// Register writes and flag handling. Status flags other than bit 7 are left to software.
	always_comb begin
		wr_pend_d = addr_ph & hwrite;
		wr_addr_d = addr_ph ? haddr : wr_addr_q;
		ctrl_d = ctrl_q;
		ena_d = ena_q;
		lvl_d = lvl_q;
		boot_d = boot_q;
		flag_d = flag_q & ~clr_src;
		if (wr_pend_q) begin
			case (wr_addr_q)
				cis_pkg::ADDR_CTRL:   ctrl_d = hwdata[3:0];
				cis_pkg::ADDR_ENABLE: ena_d = hwdata[cis_pkg::NUM_SRC-1:0];
				cis_pkg::ADDR_FLAGS:  flag_d = flag_d & ~hwdata[cis_pkg::NUM_SRC-1:0]; // [RQ11]
				cis_pkg::ADDR_LEVEL:  lvl_d = hwdata[cis_pkg::NUM_SRC-1:0];
				cis_pkg::ADDR_BOOT:   boot_d = hwdata[cis_pkg::PC_W-1:0];
				default: ;
			endcase
		end
		// Events set flags regardless of the global enable; set wins over clear. [RQ12]
		flag_d = flag_d | src_event;
		rdata_d = rdata_q;
		if (addr_ph && !hwrite) begin
			case (haddr)
				cis_pkg::ADDR_CTRL:   rdata_d = {28'h0, ctrl_q};
				cis_pkg::ADDR_SFLAGS: rdata_d = {24'h0, sflags_q};
				cis_pkg::ADDR_ENABLE: rdata_d = {24'h0, ena_q};
				cis_pkg::ADDR_FLAGS:  rdata_d = {24'h0, flag_q};
				cis_pkg::ADDR_LEVEL:  rdata_d = {24'h0, lvl_q};
				cis_pkg::ADDR_SP:     rdata_d = {16'h0, sp_q};
				cis_pkg::ADDR_BOOT:   rdata_d = {19'h0, boot_q};
				cis_pkg::ADDR_STATUS: rdata_d = {27'h0, st_q};
				default:              rdata_d = 32'h0;
			endcase
		end
	end

	// Bus writes to status flags and stack pointer override the sequencer's own update.
	logic [7:0]               sflags_w;
	logic [cis_pkg::SP_W-1:0] sp_w;
	always_comb begin
		sflags_w = sflags_d;
		sp_w = sp_d;
		if (wr_pend_q && wr_addr_q == cis_pkg::ADDR_SFLAGS)
			sflags_w = hwdata[7:0]; // [RQ8]
		if (wr_pend_q && wr_addr_q == cis_pkg::ADDR_SP)
			sp_w = hwdata[cis_pkg::SP_W-1:0];
	end

	// Single clock domain, no divider. [RQ1]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rdata_q <= '0;
			sflags_q <= cis_pkg::SFLAGS_RST;
			ctrl_q <= '0;
			ena_q <= '0;
			flag_q <= '0;
			lvl_q <= '0;
			sp_q <= cis_pkg::SP_RST;
			boot_q <= cis_pkg::BOOT_START_RST;
			st_q <= cis_pkg::ST_RUN;
			cnt_q <= '0;
			hold_q <= 1'b0;
			vec_q <= cis_pkg::RESET_VEC;
			pcsave_q <= '0;
			take_q <= 1'b0;
			load_q <= 1'b0;
			push_q <= 1'b0;
			pop_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q <= rdata_d;
			sflags_q <= sflags_w;
			ctrl_q <= ctrl_d;
			ena_q <= ena_d;
			flag_q <= flag_d;
			lvl_q <= lvl_d;
			sp_q <= sp_w;
			boot_q <= boot_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			hold_q <= hold_d;
			vec_q <= vec_d;
			pcsave_q <= pcsave_d;
			take_q <= take_d;
			load_q <= load_d;
			push_q <= push_d;
			pop_q <= pop_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, straight from flip-flops except the constant bus answers and the vector_pc select.
	// Reset vector is the boot start when the fuse bit is set. [RQ6]
	logic [cis_pkg::PC_W-1:0] rst_vec_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rst_vec_q <= cis_pkg::RESET_VEC;
		else
			rst_vec_q <= ctrl_q[cis_pkg::BRST_BIT] ? boot_q : cis_pkg::RESET_VEC;
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq_take = take_q;
	assign vector_pc = (st_q == cis_pkg::ST_RUN) ? rst_vec_q : vec_q;
	assign pc_load = load_q;
	assign stack_pc = pcsave_q;
	assign stack_push = push_q;
	assign stack_pop = pop_q;
	assign stack_ptr = sp_q;
	assign global_en = sflags_q[cis_pkg::GIE_BIT];

endmodule

// file: design/cis_pkg.sv
// Package of constants and types for the CPU interrupt sequencer.
package cis_pkg;
	localparam int NUM_SRC = 8;
	localparam int PC_W = 13;
	localparam int SP_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_SFLAGS = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_LEVEL = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_SP = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_BOOT = 12'h018;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h01c;

	// Field positions.
	localparam int GIE_BIT = 7;
	localparam int VSEL_BIT = 1;
	localparam int BRST_BIT = 0;
	localparam int LOCK_APP_BIT = 2;
	localparam int LOCK_BOOT_BIT = 3;

	// Reset values and step constants.
	localparam logic [7:0] SFLAGS_RST = 8'h00;
	localparam logic [SP_W-1:0] SP_RST = 16'h04ff;
	localparam logic [PC_W-1:0] BOOT_START_RST = 13'h1c00;
	localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
	localparam logic [PC_W-1:0] VEC_STRIDE = 13'h0002;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [SP_W-1:0] SP_STEP = 16'h0002;

	// Timing.
	localparam int CLK_MHZ = 40;
	localparam int ENTRY_CYC = 4;
	localparam int WAKE_CYC = 4;
	localparam int RETURN_CYC = 4;
	localparam int JUMP_CYC = 3;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;

	// Instruction kinds presented by the pipeline.
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_SEI = 3'h1;
	localparam logic [2:0] OP_CLI = 3'h2;
	localparam logic [2:0] OP_RET_IRQ = 3'h3;
	localparam logic [2:0] OP_JMP = 3'h4;

	typedef enum logic [4:0] {
		ST_RUN   = 5'b00001,
		ST_WAKE  = 5'b00010,
		ST_ENTRY = 5'b00100,
		ST_RET   = 5'b01000,
		ST_JUMP  = 5'b10000
	} cis_state_type;
endpackage

// file: bench/cis_sequencer_sva.sv
// Port-level timing checks of the interrupt sequencer.
`timescale 1ns/1ps
module cis_sequencer_sva (
	input wire logic                     clock,      // Core clock.
	input wire logic                     rst,        // Reset.
	input wire logic                     instr_done, // Instruction done.
	input wire logic [2:0]               instr_op,   // Instruction kind.
	input wire logic                     sleeping,   // Core asleep.
	input wire logic                     irq_take,   // Entry in progress.
	input wire logic                     pc_load,    // Vector load.
	input wire logic                     stack_push, // Push strobe.
	input wire logic                     stack_pop,  // Pop strobe.
	input wire logic [cis_pkg::SP_W-1:0] stack_ptr,  // Stack pointer.
	input wire logic                     global_en,  // Global enable.
	input wire logic                     hreadyout,  // Bus ready.
	input wire logic                     hresp       // Bus response.
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	take_gie_a: assert property ($rose(irq_take) |-> $past(global_en) && !global_en)
		else $error("entry without global enable or enable left set");
	entry_len_a: assert property ($rose(irq_take) && !sleeping |-> !pc_load[*4] ##1 pc_load)
		else $error("awake entry length wrong");
	wake_len_a: assert property ($rose(irq_take) && sleeping |-> !pc_load[*8] ##1 pc_load)
		else $error("wake entry length wrong");
	push_sp_a: assert property (pc_load |-> $past(stack_push) && stack_ptr == $past(stack_ptr, 2) - cis_pkg::SP_STEP)
		else $error("entry push or stack step wrong");
	ret_en_a: assert property (stack_pop |-> ##[3:4] global_en)
		else $error("return did not set global enable");
	// The clear takes hold at once, so not even a same-cycle request starts entry.
	cli_block_a: assert property (instr_done && instr_op == cis_pkg::OP_CLI |=> !$rose(irq_take) && !global_en)
		else $error("entry after clear-enable");
	sei_hold_a: assert property (instr_done && instr_op == cis_pkg::OP_SEI |=> !$rose(irq_take) && global_en)
		else $error("entry right after set-enable");
	bus_ok_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
endmodule

// file: bench/cis_pipe_model.sv
// Pipeline model that retires single-cycle instructions and follows vectors.
`timescale 1ns/1ps
module cis_pipe_model (
	input wire logic                     clock,      // Core clock.
	input wire logic                     rst,        // Reset.
	input wire logic                     run,        // Pipeline awake.
	input wire logic [2:0]               op_req,     // Next instruction kind.
	input wire logic                     irq_take,   // Halt for entry.
	input wire logic                     pc_load,    // Vector load.
	input wire logic                     stack_pop,  // Return pop.
	input wire logic [cis_pkg::PC_W-1:0] vector_pc,  // Vector target.
	output logic                         instr_done, // Instruction done.
	output logic      [2:0]              instr_op,   // Instruction kind.
	output logic      [cis_pkg::PC_W-1:0] pc_in      // Next program counter.
);
	// Only single-cycle instructions retire, so nothing is ever cut short.
	// Handlers here never touch the status flags, so nothing needs saving.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			instr_done <= 1'b0;
			instr_op <= cis_pkg::OP_NONE;
			pc_in <= 13'h0100;
		end else begin
			instr_done <= run && !irq_take;
			instr_op <= (run && !irq_take) ? op_req : cis_pkg::OP_NONE;
			if (pc_load)
				pc_in <= vector_pc;
			else if (stack_pop)
				pc_in <= 13'h0100;
			else if (run && !irq_take)
				pc_in <= pc_in + 13'h0001;
		end
	end
endmodule

// file: bench/cpu_interrupt_sequencer_tb_top.sv
// Top testbench of the interrupt sequencer.
`timescale 1ns/1ps
module cpu_interrupt_sequencer_tb_top;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic        hsel = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0]  src_event = 8'h00;
	logic [7:0]  src_level = 8'h00;
	logic        sleeping = 1'b0;
	logic        run = 1'b0;
	logic [2:0]  op_req = 3'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [12:0] pc_in, vector_pc;
	logic [15:0] stack_ptr;
	logic [2:0]  instr_op;
	logic        hready, hreadyout, hresp, instr_done, irq_take, pc_load, stack_push;
	logic        stack_pop, global_en;
	int          n_fail = 0;
	int          checks = 0;
	always #12.5 clock = ~clock;
	assign hready = hreadyout;
	cis_sequencer dut (.clock, .rst, .haddr, .htrans, .hwrite, .hsize, .hsel, .hready, .hwdata,
		.hrdata, .hreadyout, .hresp, .src_event, .src_level, .instr_done, .instr_op, .sleeping,
		.pc_in, .irq_take, .vector_pc, .pc_load, .stack_pc(), .stack_push, .stack_pop,
		.stack_ptr, .global_en);
	cis_pipe_model pipe (.clock, .rst, .run, .op_req, .irq_take, .pc_load, .stack_pop,
		.vector_pc, .instr_done, .instr_op, .pc_in);
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// The event lags the op by one edge so both reach the sequencer in one cycle.
	task automatic pulse(input logic [2:0] o, input logic [7:0] m);
		@(posedge clock);
		op_req <= o;
		@(posedge clock);
		op_req <= cis_pkg::OP_NONE;
		src_event <= m;
		@(posedge clock);
		src_event <= 8'h00;
	endtask
	// Sampled on the falling edge so the one-cycle load strobe is settled.
	task automatic wait_load(input logic [12:0] exp);
		int i;
		i = 0;
		do begin
			@(negedge clock);
			i++;
		end while (pc_load !== 1'b1 && i < 60);
		chk({19'h0, vector_pc}, {19'h0, exp});
		repeat (4) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		run <= 1'b1;
		rdc(cis_pkg::ADDR_SP, 32'h000004ff);
		rdc(cis_pkg::ADDR_SFLAGS, 32'h0);
		rdc(cis_pkg::ADDR_BOOT, 32'h00001c00);
		wr(cis_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(negedge clock);
		chk({19'h0, vector_pc}, 32'h00001c00);
		wr(cis_pkg::ADDR_CTRL, 32'h0);
		rdc(12'h040, 32'h0);
		wr(cis_pkg::ADDR_SP, 32'h400);
		wr(cis_pkg::ADDR_ENABLE, 32'h08);
		wr(cis_pkg::ADDR_SFLAGS, 32'h80);
		pulse(cis_pkg::OP_NONE, 8'h08);
		wait_load(13'h0008);
		rdc(cis_pkg::ADDR_SP, 32'h3fe);
		rdc(cis_pkg::ADDR_FLAGS, 32'h0);
		rdc(cis_pkg::ADDR_SFLAGS, 32'h0);
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		repeat (8) @(posedge clock);
		rdc(cis_pkg::ADDR_SFLAGS, 32'h80);
		rdc(cis_pkg::ADDR_SP, 32'h400);
		wr(cis_pkg::ADDR_SFLAGS, 32'h0);
		wr(cis_pkg::ADDR_ENABLE, 32'h24);
		pulse(cis_pkg::OP_NONE, 8'h24);
		rdc(cis_pkg::ADDR_FLAGS, 32'h24);
		wr(cis_pkg::ADDR_SFLAGS, 32'h80);
		wait_load(13'h0006);
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		wait_load(13'h000c);
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		// Let the return finish so its enable set does not undo the clear below.
		repeat (8) @(posedge clock);
		wr(cis_pkg::ADDR_SFLAGS, 32'h0);
		pulse(cis_pkg::OP_NONE, 8'h02);
		wr(cis_pkg::ADDR_FLAGS, 32'h0);
		rdc(cis_pkg::ADDR_FLAGS, 32'h02);
		wr(cis_pkg::ADDR_FLAGS, 32'h02);
		rdc(cis_pkg::ADDR_FLAGS, 32'h0);
		wr(cis_pkg::ADDR_CTRL, 32'h2);
		wr(cis_pkg::ADDR_ENABLE, 32'h01);
		pulse(cis_pkg::OP_NONE, 8'h01);
		wr(cis_pkg::ADDR_SFLAGS, 32'h80);
		wait_load(13'h1c02);
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		wr(cis_pkg::ADDR_CTRL, 32'h4);
		pulse(cis_pkg::OP_NONE, 8'h01);
		repeat (20) @(posedge clock);
		rdc(cis_pkg::ADDR_FLAGS, 32'h01);
		wr(cis_pkg::ADDR_CTRL, 32'h0);
		wait_load(13'h0002);
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		wr(cis_pkg::ADDR_ENABLE, 32'h40);
		pulse(cis_pkg::OP_CLI, 8'h40);
		repeat (10) @(posedge clock);
		rdc(cis_pkg::ADDR_SFLAGS, 32'h0);
		rdc(cis_pkg::ADDR_FLAGS, 32'h40);
		pulse(cis_pkg::OP_SEI, 8'h00);
		wait_load(13'h000e);
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		wr(cis_pkg::ADDR_LEVEL, 32'h10);
		wr(cis_pkg::ADDR_ENABLE, 32'h10);
		wr(cis_pkg::ADDR_SFLAGS, 32'h0);
		src_level <= 8'h10;
		repeat (3) @(posedge clock);
		src_level <= 8'h00;
		wr(cis_pkg::ADDR_SFLAGS, 32'h80);
		pulse(cis_pkg::OP_NONE, 8'h80);
		repeat (10) @(posedge clock);
		rdc(cis_pkg::ADDR_SFLAGS, 32'h80);
		src_level <= 8'h10;
		wait_load(13'h000a);
		src_level <= 8'h00;
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		// The post-return hold is cleared only by a retired instruction, so stay awake until then.
		repeat (8) @(posedge clock);
		wr(cis_pkg::ADDR_ENABLE, 32'h01);
		run <= 1'b0;
		sleeping <= 1'b1;
		pulse(cis_pkg::OP_NONE, 8'h01);
		wait_load(13'h0002);
		sleeping <= 1'b0;
		run <= 1'b1;
		pulse(cis_pkg::OP_RET_IRQ, 8'h00);
		repeat (8) @(posedge clock);
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		print_verdict();
	end
endmodule
bind cis_sequencer cis_sequencer_sva sva (.clock, .rst, .instr_done, .instr_op, .sleeping,
	.irq_take, .pc_load, .stack_push, .stack_pop, .stack_ptr, .global_en, .hreadyout, .hresp);
